// >>> rtl/ppfs_top.sv
// Notes on behaviour
// RL1: One pull enable bit per covered pin.
// RL2: Direction applies only while enable set.
// RL3: Output pins never pulled; pads are registered, so a pin stays pulled for one cycle after it turns output.
// RL4: Both pull registers reset to all ones.
// RL5: Ports 8-11 pull pairs, direction above enable.
// RL6: Port 12 and serial pins pull pairs.
// RL7: Direction 0 pulls down, 1 up.
// RL8: Enable 0 disables both pulls.
// RL9: Function select: port1 high nibble, port0 low.
// RL10: Codes 0,1,4,5,6 route; others reserved.
// RL11: Function select resets to zero.
// RL12: Registers read back last written byte.
`timescale 1ns/100ps
module ppfs_top (
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Output state of pins, from port logic on pclk
   input wire logic [7:0] pin_is_output,
   // Pad pull controls, order: port8..11, port12, select, input, clock
   output ppfs_pkg::ppfs_pad_s [7:0] pad_pull,
   // Function routing for ports 0 and 1
   output ppfs_pkg::ppfs_route_s port0_route,
   output ppfs_pkg::ppfs_route_s port1_route
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] pull_lo;
      logic [7:0] pull_hi;
      logic [7:0] func_sel;
      logic [31:0] rdata;
      logic ready;
      logic err;
      ppfs_pkg::ppfs_pad_s [7:0] pads;
      ppfs_pkg::ppfs_route_s route0;
      ppfs_pkg::ppfs_route_s route1;
   } ppfs_state_s;

   ppfs_state_s st_r;
   ppfs_state_s st_nxt;
   ppfs_pkg::ppfs_pad_s [7:0] pad_dec;
   logic [15:0] pull_pairs;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic ppfs_pkg::ppfs_route_s route_of(
      input logic [3:0] code
   );
      ppfs_pkg::ppfs_route_s r;
      r = '0;
      case (code) // [RL10]
         ppfs_pkg::PPFS_FN_PORT: r.port = 1'b1;
         ppfs_pkg::PPFS_FN_INT0: r.int0 = 1'b1;
         ppfs_pkg::PPFS_FN_ALT_A: r.alt_a = 1'b1;
         ppfs_pkg::PPFS_FN_ALT_B: r.alt_b = 1'b1;
         ppfs_pkg::PPFS_FN_ALT_C: r.alt_c = 1'b1;
         // Reserved codes leave the pin unrouted rather than guessing
         default: r = '0;
      endcase
      return r;
   endfunction : route_of

   function automatic logic is_mapped(input logic [11:0] a);
      return a == ppfs_pkg::PULL_CFG_LO_ADDR
         || a == ppfs_pkg::PULL_CFG_HI_ADDR
         || a == ppfs_pkg::FUNC_SEL0_ADDR
         || a == ppfs_pkg::PIN_STATUS_ADDR;
   endfunction : is_mapped

   // ------------------------------------------------------------------
   // Pull decode per pin
   // ------------------------------------------------------------------
   // Low register holds ports 8..11, high register port 12 and serial
   assign pull_pairs = {st_r.pull_hi, st_r.pull_lo}; // [RL5] [RL6]

   genvar g;
   generate
      for (g = 0; g < ppfs_pkg::NUM_PULL_PINS; g++) begin : g_pull
         ppfs_pull_decode u_dec (
            .cfg(pull_pairs[2*g +: 2]), // [RL1]
            .is_output(pin_is_output[g]),
            .pad(pad_dec[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic access;
      logic wr_ok;
      access = 1'b0;
      wr_ok = 1'b0;
      st_nxt = st_r;
      st_nxt.ready = 1'b0;
      st_nxt.err = 1'b0;
      access = psel && penable && !st_r.ready;
      // Write lands at the edge where the master samples pready high
      wr_ok = psel && penable && st_r.ready && pwrite && pstrb[0];
      // One wait state: answer comes in the cycle after the first access
      if (access) begin
         st_nxt.ready = 1'b1;
         st_nxt.err = !is_mapped(paddr);
         st_nxt.rdata = '0;
         if (!pwrite) begin
            case (paddr) // [RL12]
               ppfs_pkg::PULL_CFG_LO_ADDR:
                  st_nxt.rdata = {24'h000000, st_r.pull_lo};
               ppfs_pkg::PULL_CFG_HI_ADDR:
                  st_nxt.rdata = {24'h000000, st_r.pull_hi};
               ppfs_pkg::FUNC_SEL0_ADDR:
                  st_nxt.rdata = {24'h000000, st_r.func_sel};
               ppfs_pkg::PIN_STATUS_ADDR: st_nxt.rdata = {24'h000000,
                  pin_is_output};
               default: st_nxt.rdata = '0;
            endcase
         end
      end
      if (wr_ok) begin
         case (paddr) // [RL12]
            ppfs_pkg::PULL_CFG_LO_ADDR: st_nxt.pull_lo = pwdata[7:0];
            ppfs_pkg::PULL_CFG_HI_ADDR: st_nxt.pull_hi = pwdata[7:0];
            ppfs_pkg::FUNC_SEL0_ADDR: st_nxt.func_sel = pwdata[7:0];
            default: st_nxt.pull_lo = st_r.pull_lo;
         endcase
      end
      st_nxt.pads = pad_dec; // [RL2] [RL3]
      st_nxt.route0 = route_of(
         st_r.func_sel[ppfs_pkg::PORT0_CODE_LSB +: 4]); // [RL9]
      st_nxt.route1 = route_of(
         st_r.func_sel[ppfs_pkg::PORT1_CODE_LSB +: 4]); // [RL9]
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         st_r.pull_lo <= ppfs_pkg::PULL_CFG_RESET; // [RL4]
         st_r.pull_hi <= ppfs_pkg::PULL_CFG_RESET; // [RL4]
         st_r.func_sel <= ppfs_pkg::FUNC_SEL_RESET; // [RL11]
         st_r.route0.port <= 1'b1; // [RL11]
         st_r.route1.port <= 1'b1; // [RL11]
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.rdata;
   assign pready = st_r.ready;
   assign pslverr = st_r.err;
   assign pad_pull = st_r.pads;
   assign port0_route = st_r.route0;
   assign port1_route = st_r.route1;

endmodule : ppfs_top

// >>> rtl/ppfs_pkg.sv
package ppfs_pkg;

   // ------------------------------------------------------------------
   // Register indices and byte addresses
   // ------------------------------------------------------------------
   // Some printed offsets are not multiples of four, so each offset is an
   // index and the APB byte address is four times it.
   localparam logic [8:0] PULL_CFG_LO_IDX = 9'h19A;
   localparam logic [8:0] PULL_CFG_HI_IDX = 9'h19B;
   localparam logic [8:0] FUNC_SEL0_IDX = 9'h1A0;
   localparam logic [8:0] PIN_STATUS_IDX = 9'h1A8;
   localparam logic [11:0] PULL_CFG_LO_ADDR = {1'b0, PULL_CFG_LO_IDX, 2'b00};
   localparam logic [11:0] PULL_CFG_HI_ADDR = {1'b0, PULL_CFG_HI_IDX, 2'b00};
   localparam logic [11:0] FUNC_SEL0_ADDR = {1'b0, FUNC_SEL0_IDX, 2'b00};
   localparam logic [11:0] PIN_STATUS_ADDR = {1'b0, PIN_STATUS_IDX, 2'b00};

   // ------------------------------------------------------------------
   // Reset values and field layout
   // ------------------------------------------------------------------
   localparam logic [7:0] PULL_CFG_RESET = 8'hFF;
   localparam logic [7:0] FUNC_SEL_RESET = 8'h00;
   localparam int PULL_DIR_BIT = 1;
   localparam int PULL_EN_BIT = 0;
   localparam int PORT1_CODE_LSB = 4;
   localparam int PORT0_CODE_LSB = 0;
   localparam int NUM_PULL_PINS = 8;

   // Function codes of one 4-bit selector
   typedef enum logic [3:0] {
      PPFS_FN_PORT = 4'h0,
      PPFS_FN_INT0 = 4'h1,
      PPFS_FN_ALT_A = 4'h4,
      PPFS_FN_ALT_B = 4'h5,
      PPFS_FN_ALT_C = 4'h6
   } ppfs_func_e;

   // Per-pin pad drive controls
   typedef struct packed {
      logic pull_up;
      logic pull_down;
   } ppfs_pad_s;

   // Routing of one function-selected pin, one-hot over the choices, or all zero for a reserved code
   typedef struct packed {
      logic port;
      logic int0;
      logic alt_a;
      logic alt_b;
      logic alt_c;
   } ppfs_route_s;

endpackage : ppfs_pkg

// >>> rtl/ppfs_pull_decode.sv
`timescale 1ns/100ps
module ppfs_pull_decode (
   // Configuration for one pin
   input wire logic [1:0] cfg,
   input wire logic is_output,
   // Pad controls
   output ppfs_pkg::ppfs_pad_s pad
);
   always_comb begin
      pad.pull_up = 1'b0;
      pad.pull_down = 1'b0;
      // Output pins never pull; enable gates the direction choice
      if (!is_output && cfg[ppfs_pkg::PULL_EN_BIT]) begin // [RL2] [RL3] [RL8]
         pad.pull_up = cfg[ppfs_pkg::PULL_DIR_BIT]; // [RL7]
         pad.pull_down = !cfg[ppfs_pkg::PULL_DIR_BIT]; // [RL7]
      end
   end
endmodule : ppfs_pull_decode

// >>> testbench/ppfs_chk_sva.sv
`timescale 1ns/100ps
// ----------------------
// Port-level checks
// ----------------------
module ppfs_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pads and routes
   input wire logic [7:0] pin_is_output,
   input ppfs_pkg::ppfs_pad_s [7:0] pad_pull,
   input ppfs_pkg::ppfs_route_s port0_route,
   input ppfs_pkg::ppfs_route_s port1_route
);
   logic [7:0] pup;
   logic [7:0] pdn;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pup[i] = pad_pull[i].pull_up;
         pdn[i] = pad_pull[i].pull_down;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence taken_s; psel && penable && !pready; endsequence
   ready_wait_a: assert property (taken_s |=> pready)
      else $error("ready late");
   ready_cause_a: assert property (pready |-> $past(psel && penable))
      else $error("stray ready");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held");
   err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad error reply");
   rdata_top_a: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   pull_excl_a: assert property ((pup & pdn) == 8'h00)
      else $error("both pulls on");
   // Pads are registered, so they follow the pin state of the last cycle
   pull_out_a: assert property (
      ((pup | pdn) & $past(pin_is_output)) == 8'h00) else $error("out pulled");
   route_hot_a: assert property (
      $onehot0(port0_route) && $onehot0(port1_route)) else $error("route");
endmodule : ppfs_chk

// >>> testbench/pad_pull_and_function_select_tb_top.sv
`timescale 1ns/100ps
module pad_pull_and_function_select_tb_top;
   localparam logic [11:0] LO = ppfs_pkg::PULL_CFG_LO_ADDR;
   localparam logic [11:0] HI = ppfs_pkg::PULL_CFG_HI_ADDR;
   localparam logic [11:0] FS = ppfs_pkg::FUNC_SEL0_ADDR;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h1;
   logic [7:0] pin_is_output = 8'h00;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er;
   ppfs_pkg::ppfs_pad_s [7:0] pad_pull;
   ppfs_pkg::ppfs_route_s port0_route, port1_route;
   int n_fail = 0;
   int n_tests = 0;
   // Rows: written byte, expected port1 route, expected port0 route
   logic [17:0] rows [9] = '{{8'h10, 5'h08, 5'h10}, {8'h45, 5'h04, 5'h02},
      {8'h60, 5'h01, 5'h10}, {8'h04, 5'h10, 5'h04}, {8'h56, 5'h02, 5'h01},
      {8'h01, 5'h10, 5'h08}, {8'h27, 5'h00, 5'h00}, {8'hA3, 5'h00, 5'h00},
      {8'h00, 5'h10, 5'h10}};
   logic [7:0] outs [3] = '{8'h00, 8'hFF, 8'h44};
   ppfs_top uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_is_output(pin_is_output), .pad_pull(pad_pull),
      .port0_route(port0_route), .port1_route(port1_route));
   always #2 pclk = ~pclk;
   // ----------------------
   // Expectation and bus
   // ----------------------
   function automatic logic [15:0] epad(logic [15:0] c, logic [7:0] o);
      for (int i = 0; i < 8; i++) begin
         epad[2*i +: 2] = (c[2*i] && !o[i]) ?
            {c[2*i+1], !c[2*i+1]} : 2'b00;
      end
   endfunction : epad
   task give_verdict;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   task chk(input logic [31:0] g, input logic [31:0] x);
      n_tests++;
      if (g !== x) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk
   // Ready is sampled at the rising edge; the release follows at that edge
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d,
      input logic s);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= {3'h0, s};
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin n_fail++; give_verdict; end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rdc(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 8'h00, 1'b1);
      chk(rd, x);
   endtask : rdc
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rdc(LO, 32'hFF);
      rdc(HI, 32'hFF);
      rdc(FS, 32'h00);
      chk({16'h0, pad_pull}, 32'hAAAA);
      chk({22'h0, port1_route, port0_route}, 32'h210);
      $display("test reset done");
      foreach (rows[i]) begin
         apb(1'b1, FS, rows[i][17:10], 1'b1);
         rdc(FS, {24'h0, rows[i][17:10]});
         @(negedge pclk);
         chk({22'h0, port1_route, port0_route}, {22'h0, rows[i][9:0]});
      end
      $display("test codes done");
      apb(1'b1, LO, 8'h9C, 1'b1);
      apb(1'b1, HI, 8'h3E, 1'b1);
      foreach (outs[i]) begin
         @(posedge pclk);
         pin_is_output <= outs[i];
         repeat (2) @(negedge pclk);
         chk({16'h0, pad_pull}, {16'h0, epad(16'h3E9C, outs[i])});
      end
      apb(1'b1, LO, 8'h00, 1'b0);
      rdc(LO, 32'h9C);
      apb(1'b0, 12'h004, 8'h00, 1'b1);
      chk({rd[30:0], er}, 32'h1);
      $display("test pulls done");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(HI, 32'hFF);
      chk({16'h0, pad_pull}, {16'h0, epad(16'hFFFF, 8'h44)});
      $display("test second reset done");
      give_verdict;
   end
endmodule : pad_pull_and_function_select_tb_top
bind ppfs_top ppfs_chk u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pin_is_output(pin_is_output), .pad_pull(pad_pull),
   .port0_route(port0_route), .port1_route(port1_route));
